// File: rtl/mult_block_pkg.sv
// ---------------------------------------------------------------------------
// Register map, field layout and widths of the multiplier block.
// ---------------------------------------------------------------------------
package mult_block_pkg;

   // Datapath widths.
   localparam int WIDE_W   = 18;
   localparam int NARROW_W = 9;
   localparam int PROD_W   = 36;
   localparam int HALF_P_W = 18;

   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_OPERAND_A = 8'h04;
   localparam logic [7:0] OFF_OPERAND_B = 8'h08;
   localparam logic [7:0] OFF_RESULT_LO = 8'h0c;
   localparam logic [7:0] OFF_RESULT_HI = 8'h10;
   localparam logic [7:0] OFF_STATUS    = 8'h14;

   // Control register field positions.
   localparam int CTRL_DUAL    = 0;
   localparam int CTRL_REG_A   = 1;
   localparam int CTRL_REG_B   = 2;
   localparam int CTRL_REG_SGN = 3;
   localparam int CTRL_REG_OUT = 4;
   localparam int CTRL_SIGN_A  = 5;
   localparam int CTRL_SIGN_B  = 6;
   localparam int CTRL_CE      = 7;
   localparam int CTRL_CLEAR   = 8;
   localparam int CTRL_W       = 9;

   // Reset values.
   localparam logic [8:0]  CTRL_RESET    = 9'h000;
   localparam logic [17:0] OPERAND_RESET = 18'h00000;
   localparam logic [35:0] PROD_RESET    = 36'h000000000;

   // Operating modes.
   typedef enum logic
   {
      MODE_WIDE = 1'b0,
      MODE_DUAL = 1'b1
   } mode_t;

endpackage : mult_block_pkg

// File: rtl/mult_block.sv
// Operation
// - One wide or two narrow independent multipliers.
// - Operands registered or bypassed, mode-sized sections.
// - Register-or-bypass chosen per operand.
// - Input registers have clock, enable, async clear.
// - All datapath registers share one clock, enable, clear.
// - Sign controls select signed or unsigned operands.
// - Product signed if any operand signed, full precision.
// - Both narrow multipliers share the two sign controls.
// - Product optionally registered in mode-sized sections.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
module mult_block
#(
   // Datapath widths; the array below is laid out for exactly these values.
   parameter int WIDE_W   = mult_block_pkg::WIDE_W,
   parameter int NARROW_W = mult_block_pkg::NARROW_W,
   parameter int PROD_W   = mult_block_pkg::PROD_W
)
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   // ------------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------------

   // The bus fields and the split into two narrow products assume these
   // widths; any other value would silently misplace bits, so it is refused.
   if (WIDE_W != mult_block_pkg::WIDE_W || NARROW_W != mult_block_pkg::NARROW_W
       || PROD_W != mult_block_pkg::PROD_W)
   begin : g_width_check
      $error("mult_block: unsupported datapath width");
   end

   // ------------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------------

   // A transfer is served in the first access cycle; pready is the qualifier.
   // Only the six aligned word addresses decode; anything else is refused.
   logic        [mult_block_pkg::CTRL_W-1:0] ctrl;
   logic        [mult_block_pkg::WIDE_W-1:0] operand_a;
   logic        [mult_block_pkg::WIDE_W-1:0] operand_b;
   wire logic   setup_phase = psel & ~penable;
   wire logic   hit_ctrl    = paddr == mult_block_pkg::OFF_CTRL;
   wire logic   hit_a       = paddr == mult_block_pkg::OFF_OPERAND_A;
   wire logic   hit_b       = paddr == mult_block_pkg::OFF_OPERAND_B;
   wire logic   hit_lo      = paddr == mult_block_pkg::OFF_RESULT_LO;
   wire logic   hit_hi      = paddr == mult_block_pkg::OFF_RESULT_HI;
   wire logic   hit_status  = paddr == mult_block_pkg::OFF_STATUS;
   wire logic   mapped      = hit_ctrl | hit_a | hit_b | hit_lo | hit_hi | hit_status;
   wire logic   wr_commit   = psel & penable & pready & pwrite & ~pslverr;

   // ------------------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------------------

   // All datapath registers see the same enable and the same clear.
   wire mult_block_pkg::mode_t mode = mult_block_pkg::mode_t'(ctrl[mult_block_pkg::CTRL_DUAL]);
   wire logic reg_a_en   = ctrl[mult_block_pkg::CTRL_REG_A];
   wire logic reg_b_en   = ctrl[mult_block_pkg::CTRL_REG_B];
   wire logic reg_sgn_en = ctrl[mult_block_pkg::CTRL_REG_SGN];
   wire logic reg_out_en = ctrl[mult_block_pkg::CTRL_REG_OUT];
   wire logic shared_ce  = ctrl[mult_block_pkg::CTRL_CE];
   // The clear comes from a flop, so it is glitch free as an async reset.
   // It is level sensitive: the datapath stays at zero while the bit is set.
   wire logic dp_clr_n   = presetn & ~ctrl[mult_block_pkg::CTRL_CLEAR];

   // ------------------------------------------------------------------------
   // Input registers
   // ------------------------------------------------------------------------

   logic [mult_block_pkg::WIDE_W-1:0] in_reg_a;
   logic [mult_block_pkg::WIDE_W-1:0] in_reg_b;
   logic                              in_reg_sign_a;
   logic                              in_reg_sign_b;

   // One stage for each operand and for the sign pair, cleared asynchronously.
   // The sign pair has a stage of its own so that it can stay aligned with
   // registered operands while the sign controls change.
   always_ff @(posedge pclk or negedge dp_clr_n)
   begin
      if (!dp_clr_n)
      begin
         in_reg_a      <= mult_block_pkg::OPERAND_RESET;
         in_reg_b      <= mult_block_pkg::OPERAND_RESET;
         in_reg_sign_a <= 1'b0;
         in_reg_sign_b <= 1'b0;
      end
      else if (shared_ce)
      begin
         in_reg_a      <= operand_a;
         in_reg_b      <= operand_b;
         in_reg_sign_a <= ctrl[mult_block_pkg::CTRL_SIGN_A];
         in_reg_sign_b <= ctrl[mult_block_pkg::CTRL_SIGN_B];
      end
   end

   // Each operand picks its own path; the full 18 bits carry both halves.
   wire logic [17:0] mul_a  = reg_a_en ? in_reg_a : operand_a;
   wire logic [17:0] mul_b  = reg_b_en ? in_reg_b : operand_b;
   wire logic        sign_a = reg_sgn_en ? in_reg_sign_a : ctrl[mult_block_pkg::CTRL_SIGN_A];
   wire logic        sign_b = reg_sgn_en ? in_reg_sign_b : ctrl[mult_block_pkg::CTRL_SIGN_B];

   // ------------------------------------------------------------------------
   // Multiplier stage
   // ------------------------------------------------------------------------

   // Each operand is extended by one bit, sign or zero, so one signed
   // multiply covers all four sign combinations at full precision.
   wire logic signed [18:0] ext_a  = {sign_a & mul_a[17], mul_a};
   wire logic signed [18:0] ext_b  = {sign_b & mul_b[17], mul_b};
   wire logic signed [37:0] wide_p = ext_a * ext_b;

   // Both narrow multipliers use the same sign pair.
   wire logic signed [9:0]  ext_a0 = {sign_a & mul_a[8], mul_a[8:0]};
   wire logic signed [9:0]  ext_b0 = {sign_b & mul_b[8], mul_b[8:0]};
   wire logic signed [9:0]  ext_a1 = {sign_a & mul_a[17], mul_a[17:9]};
   wire logic signed [9:0]  ext_b1 = {sign_b & mul_b[17], mul_b[17:9]};
   wire logic signed [19:0] nar_p0 = ext_a0 * ext_b0;
   wire logic signed [19:0] nar_p1 = ext_a1 * ext_b1;

   // The upper half of the result belongs to the second narrow multiplier.
   // A result read while the operands change may mix old and new halves;
   // software writes both operands first and then reads both halves.
   wire logic [35:0] product = (mode == mult_block_pkg::MODE_DUAL)
                               ? {nar_p1[17:0], nar_p0[17:0]}
                               : wide_p[35:0];

   // ------------------------------------------------------------------------
   // Output register
   // ------------------------------------------------------------------------

   logic [mult_block_pkg::PROD_W-1:0] out_reg;

   // Two 18-bit sections share the control; in wide mode they act as one.
   // All 36 bits load together, so both halves always hold one product.
   always_ff @(posedge pclk or negedge dp_clr_n)
   begin
      if (!dp_clr_n)
      begin
         out_reg <= mult_block_pkg::PROD_RESET;
      end
      else if (shared_ce)
      begin
         out_reg <= product;
      end
   end

   wire logic [35:0] result = reg_out_en ? out_reg : product;

   // ------------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------------

   // Control and operand words take effect at the committing edge only.
   // Writes to the result and status words are accepted and change nothing.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl      <= mult_block_pkg::CTRL_RESET;
         operand_a <= mult_block_pkg::OPERAND_RESET;
         operand_b <= mult_block_pkg::OPERAND_RESET;
      end
      else if (wr_commit)
      begin
         if (hit_ctrl)
            ctrl <= pwdata[mult_block_pkg::CTRL_W-1:0];
         if (hit_a)
            operand_a <= pwdata[17:0];
         if (hit_b)
            operand_b <= pwdata[17:0];
      end
   end

   // Read data is chosen here and captured in the setup cycle.
   wire logic        result_signed = sign_a | sign_b;
   wire logic [31:0] status_word   = {29'h00000000, result_signed, mode, shared_ce};
   wire logic [31:0] read_word     = hit_ctrl   ? {23'h000000, ctrl}
                                   : hit_a      ? {14'h0000, operand_a}
                                   : hit_b      ? {14'h0000, operand_b}
                                   : hit_lo     ? result[31:0]
                                   : hit_hi     ? {28'h0000000, result[35:32]}
                                   : hit_status ? status_word
                                   : 32'h00000000;

   // ------------------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------------------

   // One wait-free answer: pready rises in the first access cycle.
   // An unmapped address answers with an error and a zero word instead of
   // stalling, so a stray access never hangs the bus.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= setup_phase;
         pslverr <= setup_phase & ~mapped;
         if (setup_phase)
            prdata <= pwrite ? 32'h00000000 : read_word;
      end
   end

endmodule : mult_block

// File: verification/mult_block_monitor.sv
`timescale 1ns/1ns
module mult_block_monitor
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Bus signals
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Decode of the six aligned words and of read answers.
   wire mapped = paddr <= 8'h14 && paddr[1:0] == 2'b00;
   wire rd_ok  = pready && !pwrite;
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      psel && penable && pready;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> answer_s)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_decode_a: assert property (pready |-> pslverr == !mapped)
      else $error("slave error decode wrong");
   write_quiet_a: assert property (pready && (pwrite || !mapped) |-> prdata == 32'h0)
      else $error("read data not zero");
   status_width_a: assert property (rd_ok && paddr == 8'h14 |-> prdata[31:3] == 29'h0)
      else $error("status upper bits set");
   result_width_a: assert property (rd_ok && paddr == 8'h10 |-> prdata[31:4] == 28'h0)
      else $error("result high upper bits set");
   operand_width_a: assert property (rd_ok && paddr inside {8'h04, 8'h08}
      |-> prdata[31:18] == 14'h0)
      else $error("operand upper bits set");
   ctrl_width_a: assert property (rd_ok && paddr == 8'h00 |-> prdata[31:9] == 23'h0)
      else $error("control upper bits set");
endmodule : mult_block_monitor

bind mult_block mult_block_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// File: verification/fabric_host.sv
`timescale 1ns/1ns
module fabric_host
(
   // Clock
   input wire logic         pclk,
   // Requests
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   // Answers
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // Idle bus from time zero.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer; the bus idles a cycle after it so no signal is driven twice per step.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
endmodule : fabric_host

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   int          n_mismatch, checks_done;
   // Clock of 50 ns period.
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   mult_block uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   fabric_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Comparison and bus helpers.
   task automatic chk(input string s, input logic [35:0] v, input logic [35:0] x);
      checks_done++;
      if (v !== x)
      begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", s, x, v);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, q, e);
   endtask : rd
   task automatic res(output logic [35:0] r);
      rd(8'h0c);
      r[31:0] = q;
      rd(8'h10);
      r[35:32] = q[3:0];
   endtask : res
   // Full-precision product of two operands, each extended per its sign control.
   function automatic logic [35:0] mul(input logic [17:0] a, b, input logic sa, sb);
      logic [35:0] xa, xb;
      xa = {{18{sa & a[17]}}, a};
      xb = {{18{sb & b[17]}}, b};
      return xa * xb;
   endfunction : mul
   function automatic logic [17:0] n9(input logic [8:0] x, input logic s);
      return {{9{s & x[8]}}, x};
   endfunction : n9
   // --------------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------------
   task automatic t_reset;
      rd(8'h00);
      chk("ctrl", q, 36'h0);
      wr(8'h18, 32'h1);
      chk("unmapped", e, 36'h1);
   endtask : t_reset
   task automatic t_modes;
      logic [35:0] r, x, p0, p1;
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h00, 32'h80 | i[0] | (i[2:1] << 5));
         wr(8'h04, 32'h3fe81);
         wr(8'h08, 32'h0a1ff);
         res(r);
         x = mul(18'h3fe81, 18'h0a1ff, i[1], i[2]);
         // Narrow halves: A splits into 9'h081 and 9'h1ff, B into 9'h1ff and 9'h050.
         p1 = mul(n9(9'h1ff, i[1]), n9(9'h050, i[2]), 1'b0, 1'b0);
         p0 = mul(n9(9'h081, i[1]), n9(9'h1ff, i[2]), 1'b0, 1'b0);
         if (i[0])
            x = {p1[17:0], p0[17:0]};
         chk("product", r, x);
         rd(8'h14);
         chk("status", q, {|i[2:1], i[0], 1'b1});
      end
   endtask : t_modes
   task automatic t_regs;
      logic [35:0] r;
      wr(8'h00, 32'h92); // Clock enable, A and output registered.
      wr(8'h04, 32'h3);
      wr(8'h08, 32'h5);
      res(r);
      chk("piped", r, 36'd15);
      wr(8'h00, 32'h12); // Enable off: registers must hold.
      wr(8'h04, 32'h7);
      wr(8'h08, 32'h2);
      res(r);
      chk("held", r, 36'd15);
      wr(8'h00, 32'h02);
      res(r);
      chk("mixed", r, 36'd6);
      wr(8'h00, 32'h112); // Clear with the output register in use.
      res(r);
      chk("out cleared", r, 36'h0);
      wr(8'h00, 32'h102);
      res(r);
      chk("cleared", r, 36'h0);
      wr(8'h00, 32'h82);
      res(r);
      chk("reloaded", r, 36'd14);
      wr(8'h08, 32'h3);
      wr(8'h04, 32'h3ffff);
      wr(8'h00, 32'hae); // Both operands and the sign pair piped, A signed.
      res(r);
      chk("all piped", r, 36'hffffffffd);
      wr(8'h00, 32'h0e); // Enable off and sign dropped: staged values must hold.
      wr(8'h08, 32'h5);
      res(r);
      chk("sign held", r, 36'hffffffffd);
   endtask : t_regs
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   // Main sequence, reset held for 12 cycles.
   initial
   begin
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_modes;
      t_regs;
      report_and_stop;
   end
   // Watchdog, far beyond the few hundred cycles the run needs.
   initial
   begin
      #200000;
      n_mismatch++;
      report_and_stop;
   end
endmodule : testbench
